// ==== dv/emb_bench.sv ====
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module external_memory_bus_and_boot_strap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, arst_n = 1'b0, code_source_strap_n = 1'b1;
    logic [7:0] hw_config_one = 8'hfc, req_wdata = 8'h00;
    logic boot_rom_enable = 1'b1, req_valid = 1'b0, req_indirect = 1'b0;
    logic [1:0] req_kind = 2'h0, stack_amount = 2'h0, op_mode;
    logic [15:0] req_addr = 16'h0000, fetch_start;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rsp_rdata;
    logic sfr_write = 1'b0, stack_push = 1'b0, stack_pop = 1'b0;
    logic latch_strobe_in = 1'b1, program_read_strobe_in = 1'b1;
    logic req_ready, rsp_valid, rsp_external, rsp_boot_rom, all_external;
    logic [7:0] stack_top_pointer, low_port_in, low_port_out, low_port_oe;
    logic [7:0] high_port_out;
    logic serial_port_zero_select, high_port_oe, read_strobe_n;
    logic write_strobe_n, strobe_oe, latch_strobe, latch_strobe_oe;
    logic program_read_strobe_n, program_strobe_oe;
    int errors = 0, checks_done = 0, rsp_count = 0, refused = 0;
    emb_bus u_dut (.*);
    emb_mem_model u_mem (.*);
    always #20 clock = ~clock;
    always @(posedge clock) if (rsp_valid === 1'b1) rsp_count++;
    task automatic tick(int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic do_reset;
        arst_n = 1'b0;
        tick(20);
        arst_n = 1'b1;
        tick(4);
    endtask : do_reset
    task automatic push(logic [1:0] k, logic ind, logic [15:0] a, logic [7:0] d);
        req_kind = k;
        req_indirect = ind;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) begin
            refused++;
            tick();
        end
        tick();
    endtask : push
    task automatic access(logic [1:0] k, logic ind, logic [15:0] a, logic [7:0] d);
        int n;
        n = rsp_count;
        push(k, ind, a, d);
        req_valid = 1'b0;
        for (int i = 0; i < 40 && rsp_count == n; i++) tick();
    endtask : access
    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            {latch_strobe_in, program_read_strobe_in} = i[1:0];
            code_source_strap_n = i != 0;
            do_reset();
            `CHK(op_mode, i[1:0])
            `CHK(serial_port_zero_select, i == 2)
            `CHK(all_external, i == 0)
            `CHK(stack_top_pointer, 8'h07)
            if (i != 0) begin
                access(2'h0, 1'b0, 16'h07ff, 8'h00);
                `CHK(rsp_boot_rom, i != 3)
            end
        end
        {latch_strobe_in, program_read_strobe_in, code_source_strap_n} = 3'h7;
        do_reset();
    endtask : t_modes
    task automatic t_stack;
        stack_amount = 2'h2;
        stack_push = 1'b1;
        tick();
        stack_push = 1'b0;
        `CHK(stack_top_pointer, 8'h09)
        stack_amount = 2'h1;
        stack_pop = 1'b1;
        tick();
        stack_pop = 1'b0;
        `CHK(stack_top_pointer, 8'h08)
        {sfr_addr, sfr_wdata, sfr_write, stack_push} = {16'h8130, 2'h3};
        tick();
        {sfr_write, stack_push} = 2'h0;
        tick();
        `CHK(sfr_rdata, 8'h30)
    endtask : t_stack
    task automatic t_ext;
        access(2'h2, 1'b0, 16'h9abc, 8'h5a);
        `CHK(u_mem.mem[16'h9abc], 8'h5a)
        access(2'h1, 1'b0, 16'h9abc, 8'h00);
        `CHK(rsp_rdata, 8'h5a)
        `CHK(rsp_external, 1'b1)
        {sfr_addr, sfr_wdata, sfr_write} = {16'h9212, 1'b1};
        tick();
        sfr_write = 1'b0;
        access(2'h2, 1'b1, 16'h0034, 8'ha5);
        `CHK(u_mem.addr, 16'h1234)
        u_mem.mem[16'h8100] = 8'hc3;
        access(2'h0, 1'b0, 16'h8100, 8'h00);
        `CHK(rsp_rdata, 8'hc3)
        `CHK(u_mem.addr, 16'h8100)
        access(2'h0, 1'b0, 16'h0100, 8'h00);
        `CHK(rsp_external, 1'b0)
        `CHK(u_mem.addr, 16'h0100)
        access(2'h0, 1'b0, 16'hf800, 8'h00);
        `CHK(rsp_boot_rom, 1'b1)
        access(2'h0, 1'b0, 16'hf7ff, 8'h00);
        `CHK(rsp_boot_rom, 1'b0)
    endtask : t_ext
    task automatic t_gpio;
        for (int j = 1; j < 3; j++) begin
            hw_config_one = {6'h3f, j[1:0]};
            tick(2);
            access(2'h2, 1'b0, 16'h4321, 8'h77);
            `CHK(rsp_rdata, 8'h00)
            `CHK(u_mem.mem[16'h4321] === 8'h77, 1'b0)
        end
        hw_config_one = 8'hfc;
        tick(2);
    endtask : t_gpio
    task automatic t_fill;
        int n;
        n = rsp_count;
        refused = 0;
        for (int i = 0; i < 24; i++) push(2'h2, 1'b0, 16'h2000 + 16'(i), 8'(i));
        req_valid = 1'b0;
        for (int i = 0; i < 200 && rsp_count < n + 24; i++) tick();
        `CHK(rsp_count - n, 24)
        `CHK(refused != 0, 1'b1)
        `CHK(u_mem.mem[16'h2017], 8'h17)
    endtask : t_fill
    task automatic results;
        if (errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // Whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #2000000;
        errors++;
        results();
    end
    initial begin
        do_reset();
        t_modes();
        t_stack();
        t_ext();
        t_gpio();
        t_fill();
        results();
    end
endmodule : external_memory_bus_and_boot_strap_bench
`default_nettype wire

// ==== dv/emb_bus_asserts.sv ====
`default_nettype none
module emb_bus_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Configuration and answers
    input wire logic [7:0] hw_config_one,
    input wire logic rsp_valid,
    input wire logic [7:0] stack_top_pointer,
    input wire logic [15:0] fetch_start,
    // Bus pins
    input wire logic [7:0] low_port_out,
    input wire logic [7:0] low_port_oe,
    input wire logic high_port_oe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic latch_strobe,
    input wire logic program_read_strobe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire any_low = !read_strobe_n || !write_strobe_n || !program_read_strobe_n;
    wire bus_off = hw_config_one[1:0] != 2'b00;
    sequence latch_phase;
        latch_strobe ##1 !latch_strobe;
    endsequence
    sequence strobe_phase;
        !latch_strobe ##2 rsp_valid;
    endsequence
    a_fetch_from_zero: assert property (fetch_start == 16'h0000)
        else $error("fetch start not zero");
    a_stack_after_reset: assert property ($rose(arst_n) |->
        stack_top_pointer == 8'h07) else $error("stack pointer reset wrong");
    a_cycle_order: assert property (latch_strobe |->
        latch_phase ##1 strobe_phase) else $error("bus cycle out of order");
    a_latch_first: assert property ($rose(any_low) |->
        $past(latch_strobe, 2)) else $error("strobe without latch pulse");
    a_single_strobe: assert property ($onehot0({!read_strobe_n,
        !write_strobe_n, !program_read_strobe_n})) else $error("two strobes");
    a_strobe_release: assert property ($rose(any_low) |=> any_low ##1 !any_low)
        else $error("strobe not released");
    a_write_data_held: assert property (!write_strobe_n |->
        low_port_oe == 8'hff ##1 $stable(low_port_out) && low_port_oe == 8'hff)
        else $error("write data not held");
    a_read_port_free: assert property (!read_strobe_n |->
        low_port_oe == 8'h00) else $error("low port driven in read");
    a_gpio_untouched: assert property (bus_off && $past(bus_off) |->
        low_port_oe == 8'h00 && !high_port_oe && !any_low)
        else $error("port touched while bus off");
endmodule : emb_bus_asserts
bind emb_bus emb_bus_asserts u_chk (.*);
`default_nettype wire

// ==== dv/emb_mem_model.sv ====
`default_nettype none
module emb_mem_model (
    // Bus pins
    input wire logic clock,
    input wire logic [7:0] low_port_out,
    input wire logic [7:0] high_port_out,
    input wire logic latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic program_read_strobe_n,
    // Returned data
    output logic [7:0] low_port_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [15:0] addr = 16'h0000;
    logic [7:0] last = 8'h00;
    logic drive = 1'b0;
    // Latch closes on the falling strobe; 1 ns lets registered pins settle
    always @(negedge latch_strobe) begin
        #1 addr = {high_port_out, low_port_out};
        drive = 1'b1;
    end
    always @(posedge read_strobe_n or posedge program_read_strobe_n) begin
        drive = 1'b0;
    end
    always @(posedge write_strobe_n) begin
        mem[addr] = low_port_out;
    end
    always @(posedge clock) begin
        if (drive) last <= mem[addr];
    end
    // Drives early, inputs pass two sync stages; released shows inverse
    assign low_port_in = drive ? mem[addr] : ~last;
endmodule : emb_mem_model
`default_nettype wire

// ==== logic/emb_bus.sv ====
`default_nettype none
// Function
// - Stack pointer resets to 07h, points at latest pushed entry.
// - Push increments then writes; pop reads then decrements.
// - Fetch starts at address 0000h after any reset.
// - Strap high: internal fetch below memory size, external above; low: all external but boot ROM.
// - Strap low at reset routes all code and data external until reset; boot ROM code accesses stay internal.
// - User mode boot ROM, when enabled, decodes at F800h to FFFFh.
// - Programming mode places boot ROM in lowest 2 kB.
// - Bus active only when both port select bits are zero.
// - Enabled bus shows every access; internal data phase drives zeros.
// - Program strobe for code reads; read/write strobes on port 3 bits.
// - Code uses 16-bit address; data uses pointer pair or 8-bit.
// - 8-bit data access holds page register on high port.
// - Low port multiplexes address and data, push-pull driven.
// - Low address valid at falling edge of latch strobe. Code drives the address on that same clock edge.
// - Write data driven before write strobe, held after release. Code drives the data on the same edge the strobe falls.
// - Read data sampled just before read strobe releases. Code takes the pins at the edge the strobe falls, two cycles earlier.
// - Access with ports as GPIO leaves port pins unchanged.
// - Enabled bus dedicates ports and strobes; high port carries PC high.
// - Reset samples program strobe and latch pins to choose mode.
// - Straps sampled on every reset source; modes left only by reset.
// - Serial programming uses serial port zero, baud tied to oscillator.
// - Config bit 1 clear: low port bus and data strobes; default GPIO. Code enables the bus only with bit 0 also clear.
// - Config bit 0 clear: high port address bus; default GPIO. Code enables the bus only with bit 1 also clear.
module emb_bus #(
    parameter logic [15:0] CODE_SIZE = emb_pkg::INTERNAL_CODE_SIZE,
    parameter int DEPTH = emb_pkg::FIFO_DEPTH
) (
    // Clock and reset (any reset source drives arst_n)
    input wire logic clock,
    input wire logic arst_n,
    // Straps and configuration
    input wire logic code_source_strap_n,
    input wire logic [7:0] hw_config_one,
    input wire logic boot_rom_enable,
    // Core access request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_kind,
    input wire logic req_indirect,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_wdata,
    // Core answer
    output logic rsp_valid,
    output logic rsp_external,
    output logic rsp_boot_rom,
    output logic [7:0] rsp_rdata,
    // Register port and stack operations
    input wire logic sfr_write,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [1:0] stack_amount,
    output logic [7:0] stack_top_pointer,
    output logic [15:0] fetch_start,
    output logic [1:0] op_mode,
    output logic all_external,
    output logic serial_port_zero_select,
    // Pins
    input wire logic [7:0] low_port_in,
    output logic [7:0] low_port_out,
    output logic [7:0] low_port_oe,
    output logic [7:0] high_port_out,
    output logic high_port_oe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic strobe_oe,
    output logic latch_strobe,
    output logic latch_strobe_oe,
    output logic program_read_strobe_n,
    output logic program_strobe_oe,
    input wire logic latch_strobe_in,
    input wire logic program_read_strobe_in
);
    // Pin synchronisers
    logic [10:0] sync_a;
    logic [10:0] sync_b;
    logic [7:0] page;
    logic [1:0] mode;
    logic strap_low;
    logic strap_taken;
    emb_pkg::emb_state_t state;
    logic [26:0] cur;
    logic [7:0] rdata;
    logic rsp_v;
    logic rsp_ext;
    logic rsp_boot;
    logic cur_ext;
    logic strobe_held;
    // Straps wait until both sync stages hold the pin level
    logic [1:0] strap_age;

    wire logic [7:0] low_pins = sync_b[7:0];
    wire logic strap_n_s = sync_b[8];
    wire logic latch_s = sync_b[9];
    wire logic prog_s = sync_b[10];

    // Bus is live only with both selects cleared
    wire logic bus_on = !hw_config_one[emb_pkg::CFG_LOW_GPIO_BIT]
        && !hw_config_one[emb_pkg::CFG_HIGH_GPIO_BIT];
    wire logic prog_mode = mode != emb_pkg::EMB_MODE_USER;

    function automatic logic in_boot(input logic [15:0] a, input logic pm,
            input logic en);
        if (pm) begin
            in_boot = a < emb_pkg::BOOT_SIZE;
        end else begin
            in_boot = en && (a >= emb_pkg::BOOT_USER_BASE);
        end
    endfunction : in_boot

    // FIFO word: kind, indirect, addr, wdata
    logic f_valid;
    logic f_ready;
    logic [26:0] f_data;
    emb_fifo #(.WIDTH(emb_pkg::FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_kind, req_indirect, req_addr, req_wdata}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );
    assign f_ready = state == emb_pkg::EMB_IDLE;

    wire logic [1:0] f_kind = f_data[26:25];
    wire logic [15:0] f_addr = f_data[23:8];
    wire logic f_boot = f_kind == emb_pkg::EMB_KIND_CODE
        && in_boot(f_addr, prog_mode, boot_rom_enable);
    wire logic f_ind = f_data[24];
    // Indirect data address is the page byte over the low byte
    wire logic [15:0] f_eff = f_ind ? {page, f_addr[7:0]} : f_addr;
    // Data above on-chip data memory goes out as well
    wire logic f_data_ext = f_kind != emb_pkg::EMB_KIND_CODE
        && f_eff >= emb_pkg::INTERNAL_DATA_SIZE;
    // Code above internal size, or strap low, goes out unless it hits boot ROM
    wire logic f_ext = !f_boot && (strap_low || f_data_ext
        || (f_kind == emb_pkg::EMB_KIND_CODE
        && f_addr >= CODE_SIZE));
    wire logic [1:0] c_kind = cur[26:25];
    wire logic c_ind = cur[24];
    wire logic [15:0] c_addr = cur[23:8];
    // 8-bit indirect data takes its high byte from the page register
    wire logic [7:0] c_high = (c_ind && c_kind != emb_pkg::EMB_KIND_CODE)
        ? page : c_addr[15:8];
    wire logic c_wr = c_kind == emb_pkg::EMB_KIND_WRITE;
    wire logic c_code = c_kind == emb_pkg::EMB_KIND_CODE;
    wire logic [7:0] sp_step = {6'h00, stack_amount};
    wire logic [7:0] next_sp = stack_push ? stack_top_pointer + sp_step
        : stack_pop ? stack_top_pointer - sp_step
        : stack_top_pointer;

    // Strobe selects for the data phase
    wire logic want_prog = c_code && cur_ext;
    wire logic want_read = c_kind == emb_pkg::EMB_KIND_READ && cur_ext;
    wire logic want_write = c_wr && cur_ext;

    // Reset to idle pin levels so no false strap is seen
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= 11'h7FF;
            sync_b <= 11'h7FF;
        end else begin
            sync_a <= {program_read_strobe_in, latch_strobe_in,
                code_source_strap_n, low_port_in};
            sync_b <= sync_a;
        end
    end

    // Straps caught once the sync stages carry the pins after any reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strap_taken <= 1'b0;
            strap_age <= 2'h0;
            mode <= emb_pkg::EMB_MODE_USER;
            strap_low <= 1'b0;
        end else if (!strap_taken) begin
            if (strap_age == emb_pkg::STRAP_SETTLE) begin
                strap_taken <= 1'b1;
                mode <= {latch_s, prog_s};
                strap_low <= !strap_n_s;
            end else begin
                strap_age <= strap_age + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stack_top_pointer <= emb_pkg::STACK_RESET;
            page <= emb_pkg::PAGE_RESET;
        end else if (sfr_write
                && sfr_addr == emb_pkg::SFR_STACK_TOP_POINTER) begin
            stack_top_pointer <= sfr_wdata;
        end else begin
            stack_top_pointer <= next_sp;
            if (sfr_write && sfr_addr == emb_pkg::SFR_EXTERNAL_PAGE_SELECT)
            begin
                page <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_addr == emb_pkg::SFR_STACK_TOP_POINTER) begin
            sfr_rdata <= stack_top_pointer;
        end else if (sfr_addr == emb_pkg::SFR_EXTERNAL_PAGE_SELECT) begin
            sfr_rdata <= page;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // Bus cycle: address latch, strobe, then hold for write data
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= emb_pkg::EMB_IDLE;
            cur <= '0;
            cur_ext <= 1'b0;
            rsp_v <= 1'b0;
            rsp_ext <= 1'b0;
            rsp_boot <= 1'b0;
            strobe_held <= 1'b0;
            rdata <= 8'h00;
            latch_strobe <= 1'b0;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            program_read_strobe_n <= 1'b1;
            low_port_out <= 8'h00;
            high_port_out <= 8'h00;
        end else begin
            rsp_v <= 1'b0;
            case (state)
                emb_pkg::EMB_IDLE: begin
                    read_strobe_n <= 1'b1;
                    write_strobe_n <= 1'b1;
                    program_read_strobe_n <= 1'b1;
                    if (f_valid) begin
                        cur <= f_data;
                        cur_ext <= f_ext;
                        rsp_boot <= f_boot;
                        if (bus_on) begin
                            state <= emb_pkg::EMB_ALE;
                            latch_strobe <= 1'b1;
                        end else begin
                            // Ports stay GPIO; no pin changes
                            rsp_v <= 1'b1;
                            rsp_ext <= f_ext;
                            rdata <= 8'h00;
                        end
                    end
                end
                emb_pkg::EMB_ALE: begin
                    low_port_out <= c_addr[7:0];
                    high_port_out <= c_high;
                    // Address driven on the same edge the latch strobe falls
                    latch_strobe <= 1'b0;
                    state <= emb_pkg::EMB_STROBE;
                    strobe_held <= 1'b0;
                end
                emb_pkg::EMB_STROBE: begin
                    // Internal data phase shows zeros only
                    low_port_out <= (c_wr && cur_ext) ? cur[7:0]
                        : 8'h00;
                    program_read_strobe_n <= !want_prog;
                    read_strobe_n <= !want_read;
                    write_strobe_n <= !want_write;
                    // Pins pass two sync stages; strobe stays one more cycle
                    if (strobe_held) begin
                        state <= emb_pkg::EMB_HOLD;
                    end else begin
                        strobe_held <= 1'b1;
                    end
                end
                emb_pkg::EMB_HOLD: begin
                    // Sample before strobe rises; data held one more cycle
                    rdata <= cur_ext ? low_pins : 8'h00;
                    read_strobe_n <= 1'b1;
                    write_strobe_n <= 1'b1;
                    program_read_strobe_n <= 1'b1;
                    rsp_v <= 1'b1;
                    rsp_ext <= cur_ext;
                    state <= emb_pkg::EMB_IDLE;
                end
                default: begin
                    state <= emb_pkg::EMB_IDLE;
                end
            endcase
        end
    end

    // Output enables: push-pull only while bus is active
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            low_port_oe <= 8'h00;
            high_port_oe <= 1'b0;
            strobe_oe <= 1'b0;
            latch_strobe_oe <= 1'b0;
            program_strobe_oe <= 1'b0;
        end else begin
            // Low port released in read data phase for memory to drive
            low_port_oe <= (bus_on && !(state == emb_pkg::EMB_STROBE
                && !c_wr && cur_ext)) ? 8'hFF : 8'h00;
            high_port_oe <= bus_on;
            strobe_oe <= bus_on;
            latch_strobe_oe <= strap_taken && bus_on;
            program_strobe_oe <= strap_taken && bus_on;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // Any reset source restarts fetch at the vector
            fetch_start <= emb_pkg::RESET_VECTOR;
            op_mode <= emb_pkg::EMB_MODE_USER;
            all_external <= 1'b0;
            serial_port_zero_select <= 1'b0;
        end else begin
            fetch_start <= emb_pkg::RESET_VECTOR;
            op_mode <= mode;
            all_external <= strap_low;
            serial_port_zero_select <= mode == emb_pkg::EMB_MODE_SERIAL;
        end
    end

    assign rsp_valid = rsp_v;
    assign rsp_external = rsp_ext;
    assign rsp_boot_rom = rsp_boot;
    assign rsp_rdata = rdata;
endmodule : emb_bus
`default_nettype wire

// ==== logic/emb_fifo.sv ====
`default_nettype none
module emb_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;
    wire logic full = (wr_ptr[AW] != rd_ptr[AW])
        && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end
endmodule : emb_fifo
`default_nettype wire

// ==== logic/emb_pkg.sv ====
`default_nettype none
package emb_pkg;
    localparam logic [7:0] SFR_STACK_TOP_POINTER = 8'h81;
    localparam logic [7:0] SFR_EXTERNAL_PAGE_SELECT = 8'h92;
    localparam logic [7:0] STACK_RESET = 8'h07;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] BOOT_USER_BASE = 16'hF800;
    localparam logic [15:0] BOOT_SIZE = 16'h0800;
    localparam logic [15:0] INTERNAL_CODE_SIZE = 16'h8000;
    localparam int CFG_HIGH_GPIO_BIT = 0;
    localparam int CFG_LOW_GPIO_BIT = 1;
    localparam logic [7:0] CFG_ONE_RESET = 8'hFF;
    localparam logic [15:0] INTERNAL_DATA_SIZE = 16'h0400;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 27;
    localparam int DATA_OPS_FIFO = 16;

    typedef enum logic [1:0] {
        EMB_MODE_RESERVED = 2'b00,
        EMB_MODE_PARALLEL = 2'b01,
        EMB_MODE_SERIAL = 2'b10,
        EMB_MODE_USER = 2'b11
    } emb_mode_t;

    typedef enum logic [1:0] {
        EMB_KIND_CODE = 2'b00,
        EMB_KIND_READ = 2'b01,
        EMB_KIND_WRITE = 2'b10
    } emb_kind_t;

    // Gray along idle -> latch -> strobe -> hold
    typedef enum logic [1:0] {
        EMB_IDLE = 2'b00,
        EMB_ALE = 2'b01,
        EMB_STROBE = 2'b11,
        EMB_HOLD = 2'b10
    } emb_state_t;
endpackage : emb_pkg
`default_nettype wire
